// ==== core/lkt_defs.svh ====
// Operation
// - make-entry writes the staged 64-bit entry where the device chooses
// - make-entry also modifies or removes an existing manual or learned entry
// - writing zero to a command bit does nothing; a one starts it
// - get-first rewinds the read pointer and loads the first valid entry
// - get-next advances from the read pointer to the next valid entry
// - low write data holds first 32 address bits, bit 0 multicast, resets zero
// - valid bit 26 set makes entry valid; clear invalidates matching address
// - static entry with bit 25 forwards regardless of port state except disabled
// - static bit 24 blocks aging; others expire after five to ten idle minutes; here only age-set entries do, age-clear ones go at the next sweep
// - filter bit 23 drops packets whose destination matches the entry
// - bits 18:16 encode associated ports; code 011 reserved
// - high write data bits 15:0 hold last 16 address bits
`ifndef LKT_DEFS_SVH
`define LKT_DEFS_SVH

// register numbers
`define LKT_CMD_ADDR 16'h1800
`define LKT_WR_LO_ADDR 16'h1801
`define LKT_WR_HI_ADDR 16'h1802
`define LKT_RD_LO_ADDR 16'h1805
`define LKT_RD_HI_ADDR 16'h1806
`define LKT_STS_ADDR 16'h1808

// command bits
`define LKT_CMD_NEXT_BIT 0
`define LKT_CMD_FIRST_BIT 1
`define LKT_CMD_MAKE_BIT 2
`define LKT_CMD_WIDTH 3

// high data fields
`define LKT_HI_WIDTH 27
`define LKT_RD_VALID_BIT 26
`define LKT_RD_END_BIT 31

// status bits
`define LKT_STS_PEND_BIT 0
`define LKT_STS_BUSY_BIT 1

// reset values
`define LKT_WR_LO_RESET 32'h0000_0000
`define LKT_WR_HI_RESET 27'h000_0000

// table size and aging period
`define LKT_ENTRIES 512
`define LKT_AGE_PERIOD_S 64'd300
`define LKT_CLK_HZ 64'd20000000
`define LKT_AGE_CYCLES (`LKT_AGE_PERIOD_S * `LKT_CLK_HZ)

`endif

// ==== core/lkt_pkg.sv ====
package lkt_pkg;

    // one table entry, laid out as high word over low word
    typedef struct packed {
        logic [4:0] rsvd;
        logic valid;
        logic age;
        logic static_e;
        logic filter;
        logic prio_en;
        logic [2:0] prio;
        logic [2:0] ports;
        logic [15:0] mac_hi;
        logic [31:0] mac_lo;
    } lkt_entry_t;

    typedef enum logic [2:0] {
        LKT_OP_MAKE = 3'h0,
        LKT_OP_FIRST = 3'h1,
        LKT_OP_NEXT = 3'h2,
        LKT_OP_LOOKUP = 3'h3,
        LKT_OP_AGE = 3'h4
    } lkt_op_t;

    typedef enum logic [1:0] {
        LKT_ST_IDLE = 2'h0,
        LKT_ST_RUN = 2'h1
    } lkt_state_t;

endpackage : lkt_pkg

// ==== core/lkt_table.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.svh"

module lkt_table #(
    parameter int ENTRIES = `LKT_ENTRIES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    input wire lkt_pkg::lkt_op_t op,
    input wire lkt_pkg::lkt_entry_t in_entry,
    output logic done,
    output lkt_pkg::lkt_entry_t res,
    output logic res_found,
    output logic res_end
);
    localparam int AW = $clog2(ENTRIES);
    localparam logic [AW:0] LAST = (AW+1)'(ENTRIES);

    if (ENTRIES < 2 || (1 << AW) != ENTRIES) begin : g_chk
        $error("ENTRIES must be a power of two, at least 2");
    end

    lkt_pkg::lkt_entry_t mem [ENTRIES];
    logic [ENTRIES-1:0] vld_reg, vld_next;
    logic busy_reg, busy_next, done_reg, done_next;
    lkt_pkg::lkt_op_t op_reg, op_next;
    lkt_pkg::lkt_entry_t key_reg, key_next, res_reg, res_next;
    logic [AW:0] idx_reg, idx_next, rdptr_reg, rdptr_next, free_reg, free_next;
    logic free_ok_reg, free_ok_next, found_reg, found_next, end_reg, end_next;
    logic mem_we;
    logic [AW-1:0] mem_wa;
    lkt_pkg::lkt_entry_t mem_wd, cur, aged;
    logic cur_v, hit, at_end;

    // one entry examined per cycle; a whole sweep costs ENTRIES+1 cycles
    always_comb begin
        busy_next = busy_reg;
        op_next = op_reg;
        key_next = key_reg;
        res_next = res_reg;
        idx_next = idx_reg;
        rdptr_next = rdptr_reg;
        free_next = free_reg;
        free_ok_next = free_ok_reg;
        found_next = found_reg;
        end_next = end_reg;
        vld_next = vld_reg;
        done_next = 1'b0;
        mem_we = 1'b0;
        mem_wa = idx_reg[AW-1:0];
        mem_wd = key_reg;
        cur = mem[idx_reg[AW-1:0]];
        cur_v = vld_reg[idx_reg[AW-1:0]];
        hit = cur_v && ({cur.mac_hi, cur.mac_lo} == {key_reg.mac_hi, key_reg.mac_lo});
        at_end = (idx_reg == LAST);
        aged = cur;
        aged.age = 1'b0;
        if (start) begin
            busy_next = 1'b1;
            op_next = op;
            key_next = in_entry;
            free_ok_next = 1'b0;
            found_next = 1'b0;
            end_next = 1'b0;
            idx_next = (op == lkt_pkg::LKT_OP_NEXT) ? rdptr_reg : '0;
        end else if (busy_reg) begin
            idx_next = idx_reg + 1'b1;
            if (at_end) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                case (op_reg)
                    lkt_pkg::LKT_OP_MAKE: begin
                        // no match: new entry goes to the first free slot; full table drops it
                        if (key_reg.valid && free_ok_reg) begin
                            mem_we = 1'b1;
                            mem_wa = free_reg[AW-1:0];
                            vld_next[free_reg[AW-1:0]] = 1'b1;
                        end
                    end
                    lkt_pkg::LKT_OP_FIRST, lkt_pkg::LKT_OP_NEXT: begin
                        end_next = 1'b1;
                        res_next = '0;
                        rdptr_next = LAST;
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (op_reg)
                    lkt_pkg::LKT_OP_MAKE: begin
                        if (hit) begin
                            busy_next = 1'b0;
                            done_next = 1'b1;
                            found_next = 1'b1;
                            mem_we = key_reg.valid;
                            vld_next[idx_reg[AW-1:0]] = key_reg.valid;
                        end else if (!cur_v && !free_ok_reg) begin
                            free_next = idx_reg;
                            free_ok_next = 1'b1;
                        end
                    end
                    lkt_pkg::LKT_OP_FIRST, lkt_pkg::LKT_OP_NEXT: begin
                        if (cur_v) begin
                            busy_next = 1'b0;
                            done_next = 1'b1;
                            found_next = 1'b1;
                            res_next = cur;
                            res_next.valid = 1'b1;
                            rdptr_next = idx_reg + 1'b1;
                        end
                    end
                    lkt_pkg::LKT_OP_LOOKUP: begin
                        if (hit) begin
                            busy_next = 1'b0;
                            done_next = 1'b1;
                            found_next = 1'b1;
                            res_next = cur;
                        end
                    end
                    lkt_pkg::LKT_OP_AGE: begin
                        // age set survives one sweep and goes at the next: five to ten minutes; age clear goes at the first sweep
                        if (cur_v && !cur.static_e) begin
                            mem_we = cur.age;
                            mem_wd = aged;
                            vld_next[idx_reg[AW-1:0]] = cur.age;
                        end
                    end
                    default: begin
                        busy_next = 1'b0;
                    end
                endcase
            end
        end
    end

    // entry data carries no reset; validity lives in vld_reg, which does
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vld_reg <= '0;
            busy_reg <= 1'b0;
            op_reg <= lkt_pkg::LKT_OP_MAKE;
            key_reg <= '0;
            res_reg <= '0;
            idx_reg <= '0;
            rdptr_reg <= '0;
            free_reg <= '0;
            free_ok_reg <= 1'b0;
            found_reg <= 1'b0;
            end_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            vld_reg <= vld_next;
            busy_reg <= busy_next;
            op_reg <= op_next;
            key_reg <= key_next;
            res_reg <= res_next;
            idx_reg <= idx_next;
            rdptr_reg <= rdptr_next;
            free_reg <= free_next;
            free_ok_reg <= free_ok_next;
            found_reg <= found_next;
            end_reg <= end_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
    assign res = res_reg;
    assign res_found = found_reg;
    assign res_end = end_reg;

endmodule : lkt_table
`default_nettype wire

// ==== core/lkt_command.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.svh"

module lkt_command #(
    parameter int ENTRIES = `LKT_ENTRIES,
    parameter longint unsigned AGE_CYCLES = `LKT_AGE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic fwd_req,
    input wire logic [47:0] fwd_mac,
    output logic fwd_ack,
    output logic fwd_done,
    output logic fwd_hit,
    output logic fwd_drop,
    output logic fwd_override,
    output logic [2:0] fwd_ports
);
    if (AGE_CYCLES < 64'd2 || AGE_CYCLES > 64'h1_ffff_ffff) begin : g_chk
        $error("AGE_CYCLES must lie between 2 and 2**33-1");
    end

    localparam logic [32:0] AGE_LAST = 33'(AGE_CYCLES - 64'd1);

    // port code to one bit per port; the reserved code selects nothing
    function automatic logic [2:0] lkt_port_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            3'h0: m = 3'h1;
            3'h1: m = 3'h2;
            3'h2: m = 3'h4;
            3'h4: m = 3'h3;
            3'h5: m = 3'h5;
            3'h6: m = 3'h6;
            3'h7: m = 3'h7;
            default: m = 3'h0;
        endcase
        return m;
    endfunction : lkt_port_mask

    // software-visible registers
    logic [`LKT_CMD_WIDTH-1:0] cmd_reg, cmd_next;
    logic [31:0] wr_lo_reg, wr_lo_next;
    logic [`LKT_HI_WIDTH-1:0] wr_hi_reg, wr_hi_next;
    logic [31:0] rd_lo_reg, rd_lo_next, rd_hi_reg, rd_hi_next;
    logic [31:0] rdata_reg, rdata_next;

    // command sequencing
    lkt_pkg::lkt_state_t state_reg, state_next;
    lkt_pkg::lkt_op_t run_op_reg, run_op_next;
    logic [`LKT_CMD_WIDTH-1:0] req_reg, req_next, launch;
    logic [32:0] age_cnt_reg, age_cnt_next;
    logic age_req_reg, age_req_next, age_launch;
    logic fwd_done_reg, fwd_done_next, fwd_hit_reg, fwd_hit_next;
    logic fwd_drop_reg, fwd_drop_next, fwd_ovr_reg, fwd_ovr_next;
    logic [2:0] fwd_ports_reg, fwd_ports_next;

    // table engine hookup
    logic tbl_start, tbl_done, tbl_found, tbl_end;
    lkt_pkg::lkt_op_t tbl_op;
    lkt_pkg::lkt_entry_t tbl_in, tbl_res, staged;
    logic wr_cmd, make_pend;

    assign wr_cmd = reg_wr && (reg_addr == `LKT_CMD_ADDR);
    assign staged = lkt_pkg::lkt_entry_t'({5'h00, wr_hi_reg, wr_lo_reg});

    // register writes; reserved bits are simply not stored
    always_comb begin
        cmd_next = cmd_reg;
        wr_lo_next = wr_lo_reg;
        wr_hi_next = wr_hi_reg;
        if (wr_cmd) begin
            cmd_next = reg_wdata[`LKT_CMD_WIDTH-1:0];
        end
        if (reg_wr && reg_addr == `LKT_WR_LO_ADDR) begin
            wr_lo_next = reg_wdata;
        end
        if (reg_wr && reg_addr == `LKT_WR_HI_ADDR) begin
            wr_hi_next = reg_wdata[`LKT_HI_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= '0;
            wr_lo_reg <= `LKT_WR_LO_RESET;
            wr_hi_reg <= `LKT_WR_HI_RESET;
        end else begin
            cmd_reg <= cmd_next;
            wr_lo_reg <= wr_lo_next;
            wr_hi_reg <= wr_hi_next;
        end
    end

    // pick one job when idle: register commands first, then forwarding, then aging
    always_comb begin
        launch = '0;
        age_launch = 1'b0;
        fwd_ack = 1'b0;
        tbl_start = 1'b0;
        tbl_op = lkt_pkg::LKT_OP_MAKE;
        tbl_in = staged;
        if (state_reg == lkt_pkg::LKT_ST_IDLE) begin
            if (req_reg[`LKT_CMD_MAKE_BIT]) begin
                launch[`LKT_CMD_MAKE_BIT] = 1'b1;
                tbl_start = 1'b1;
            end else if (req_reg[`LKT_CMD_FIRST_BIT]) begin
                launch[`LKT_CMD_FIRST_BIT] = 1'b1;
                tbl_start = 1'b1;
                tbl_op = lkt_pkg::LKT_OP_FIRST;
            end else if (req_reg[`LKT_CMD_NEXT_BIT]) begin
                launch[`LKT_CMD_NEXT_BIT] = 1'b1;
                tbl_start = 1'b1;
                tbl_op = lkt_pkg::LKT_OP_NEXT;
            end else if (fwd_req) begin
                fwd_ack = 1'b1;
                tbl_start = 1'b1;
                tbl_op = lkt_pkg::LKT_OP_LOOKUP;
                tbl_in = '0;
                tbl_in.mac_hi = fwd_mac[47:32];
                tbl_in.mac_lo = fwd_mac[31:0];
            end else if (age_req_reg) begin
                age_launch = 1'b1;
                tbl_start = 1'b1;
                tbl_op = lkt_pkg::LKT_OP_AGE;
            end
        end
    end

    // a one written to a command bit queues that command; a zero queues nothing.
    // a new write in the launch cycle wins over the launch clear, so none is lost
    always_comb begin
        req_next = (req_reg & ~launch) | (wr_cmd ? reg_wdata[`LKT_CMD_WIDTH-1:0] : '0);
        age_cnt_next = age_cnt_reg + 33'h0_0000_0001;
        age_req_next = age_req_reg && !age_launch;
        if (age_cnt_reg == AGE_LAST) begin
            age_cnt_next = '0;
            age_req_next = 1'b1;
        end
        state_next = state_reg;
        run_op_next = run_op_reg;
        case (state_reg)
            lkt_pkg::LKT_ST_IDLE: begin
                if (tbl_start) begin
                    state_next = lkt_pkg::LKT_ST_RUN;
                    run_op_next = tbl_op;
                end
            end
            lkt_pkg::LKT_ST_RUN: begin
                if (tbl_done) begin
                    state_next = lkt_pkg::LKT_ST_IDLE;
                end
            end
            default: begin
                state_next = lkt_pkg::LKT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req_reg <= '0;
            age_cnt_reg <= '0;
            age_req_reg <= 1'b0;
            state_reg <= lkt_pkg::LKT_ST_IDLE;
            run_op_reg <= lkt_pkg::LKT_OP_MAKE;
        end else begin
            req_reg <= req_next;
            age_cnt_reg <= age_cnt_next;
            age_req_reg <= age_req_next;
            state_reg <= state_next;
            run_op_reg <= run_op_next;
        end
    end

    // pending covers the queued command and the whole table update
    assign make_pend = req_reg[`LKT_CMD_MAKE_BIT] ||
        (state_reg == lkt_pkg::LKT_ST_RUN && run_op_reg == lkt_pkg::LKT_OP_MAKE);

    // results land when the engine finishes
    always_comb begin
        rd_lo_next = rd_lo_reg;
        rd_hi_next = rd_hi_reg;
        fwd_done_next = 1'b0;
        fwd_hit_next = fwd_hit_reg;
        fwd_drop_next = fwd_drop_reg;
        fwd_ovr_next = fwd_ovr_reg;
        fwd_ports_next = fwd_ports_reg;
        if (tbl_done && state_reg == lkt_pkg::LKT_ST_RUN) begin
            if (run_op_reg == lkt_pkg::LKT_OP_FIRST || run_op_reg == lkt_pkg::LKT_OP_NEXT) begin
                rd_lo_next = tbl_res.mac_lo;
                rd_hi_next = '0;
                rd_hi_next[25:0] = tbl_res[57:32];
                rd_hi_next[`LKT_RD_VALID_BIT] = tbl_found;
                rd_hi_next[`LKT_RD_END_BIT] = tbl_end;
            end
            if (run_op_reg == lkt_pkg::LKT_OP_LOOKUP) begin
                fwd_done_next = 1'b1;
                fwd_hit_next = tbl_found;
                fwd_drop_next = tbl_found && tbl_res.filter;
                fwd_ovr_next = tbl_found && tbl_res.static_e && tbl_res.age;
                fwd_ports_next = tbl_found ? lkt_port_mask(tbl_res.ports) : 3'h0;
            end
        end
    end

    // read data is registered: it appears one cycle after the read strobe
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            rdata_next = '0;
            case (reg_addr)
                `LKT_CMD_ADDR: rdata_next[`LKT_CMD_WIDTH-1:0] = cmd_reg;
                `LKT_WR_LO_ADDR: rdata_next = wr_lo_reg;
                `LKT_WR_HI_ADDR: rdata_next[`LKT_HI_WIDTH-1:0] = wr_hi_reg;
                `LKT_RD_LO_ADDR: rdata_next = rd_lo_reg;
                `LKT_RD_HI_ADDR: rdata_next = rd_hi_reg;
                `LKT_STS_ADDR: begin
                    rdata_next[`LKT_STS_PEND_BIT] = make_pend;
                    rdata_next[`LKT_STS_BUSY_BIT] = (state_reg != lkt_pkg::LKT_ST_IDLE);
                end
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_lo_reg <= '0;
            rd_hi_reg <= '0;
            rdata_reg <= '0;
            fwd_done_reg <= 1'b0;
            fwd_hit_reg <= 1'b0;
            fwd_drop_reg <= 1'b0;
            fwd_ovr_reg <= 1'b0;
            fwd_ports_reg <= '0;
        end else begin
            rd_lo_reg <= rd_lo_next;
            rd_hi_reg <= rd_hi_next;
            rdata_reg <= rdata_next;
            fwd_done_reg <= fwd_done_next;
            fwd_hit_reg <= fwd_hit_next;
            fwd_drop_reg <= fwd_drop_next;
            fwd_ovr_reg <= fwd_ovr_next;
            fwd_ports_reg <= fwd_ports_next;
        end
    end

    lkt_table #(
        .ENTRIES(ENTRIES)
    ) u_table (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(tbl_start),
        .op(tbl_op),
        .in_entry(tbl_in),
        .done(tbl_done),
        .res(tbl_res),
        .res_found(tbl_found),
        .res_end(tbl_end)
    );

    assign reg_rdata = rdata_reg;
    assign fwd_done = fwd_done_reg;
    assign fwd_hit = fwd_hit_reg;
    assign fwd_drop = fwd_drop_reg;
    assign fwd_override = fwd_ovr_reg;
    assign fwd_ports = fwd_ports_reg;

endmodule : lkt_command
`default_nettype wire

// ==== testbench/lkt_command_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.svh"

module lkt_command_properties #(
    parameter int ENTRIES = 8,
    parameter longint unsigned AGE_CYCLES = 2000
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic fwd_req,
    input wire logic fwd_ack,
    input wire logic fwd_done,
    input wire logic fwd_hit,
    input wire logic fwd_drop,
    input wire logic fwd_override,
    input wire logic [2:0] fwd_ports
);
    // a miss scans every entry, then the end step, the engine done register and the result register
    localparam int DONE_MAX = ENTRIES + 3;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // staging write, one idle cycle, then a read of the same word
    sequence s_lo_wr_rd;
        reg_wr && reg_addr == `LKT_WR_LO_ADDR ##1 !reg_wr ##1 reg_rd && reg_addr == `LKT_WR_LO_ADDR;
    endsequence

    // lookup taken at the ack cycle
    sequence s_taken;
        fwd_ack;
    endsequence

    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_cmd_reserved_zero: assert property (reg_rd && reg_addr == `LKT_CMD_ADDR |=> reg_rdata[31:3] == 29'h0)
        else $error("command reserved bits not zero");
    a_hi_reserved_zero: assert property (reg_rd && reg_addr == `LKT_WR_HI_ADDR |=> reg_rdata[31:27] == 5'h0)
        else $error("high data reserved bits not zero");
    a_lo_readback: assert property (s_lo_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("low write data readback wrong");
    a_ack_needs_req: assert property (fwd_ack |-> fwd_req ##1 !fwd_ack)
        else $error("lookup acknowledged without request or twice");
    a_done_after_ack: assert property (s_taken |-> ##[1:DONE_MAX] fwd_done)
        else $error("lookup result late");
    a_drop_needs_hit: assert property (fwd_done && fwd_drop |-> fwd_hit)
        else $error("drop without hit");
    a_override_needs_hit: assert property (fwd_done && fwd_override |-> fwd_hit)
        else $error("override without hit");
    a_miss_no_ports: assert property (fwd_done && !fwd_hit |-> fwd_ports == 3'h0)
        else $error("ports on a miss");
endmodule : lkt_command_properties

bind lkt_command lkt_command_properties #(.ENTRIES(ENTRIES), .AGE_CYCLES(AGE_CYCLES)) lkt_command_properties_i (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fwd_req(fwd_req), .fwd_ack(fwd_ack),
    .fwd_done(fwd_done), .fwd_hit(fwd_hit), .fwd_drop(fwd_drop), .fwd_override(fwd_override),
    .fwd_ports(fwd_ports)
);
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lkt_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    logic sys_clk, nrst, reg_wr, reg_rd, fwd_req, fwd_ack, fwd_done, fwd_hit, fwd_drop, fwd_override;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, h;
    logic [47:0] fwd_mac;
    logic [2:0] fwd_ports;
    int errors = 0;
    int checks_done = 0;
    int i;
    typedef struct packed {logic [31:0] hi; logic [2:0] ports; logic drop; logic ovr;} lkt_row_t;
    // static entries so aging leaves them alone; every port code once
    lkt_row_t rows [8] = '{'{32'h0500_a000, 3'h1, 1'b0, 1'b0}, '{32'h0701_a001, 3'h2, 1'b0, 1'b1},
        '{32'h0582_a002, 3'h4, 1'b1, 1'b0}, '{32'h0503_a003, 3'h0, 1'b0, 1'b0},
        '{32'h0784_a004, 3'h3, 1'b1, 1'b1}, '{32'h0505_a005, 3'h5, 1'b0, 1'b0},
        '{32'h0506_a006, 3'h6, 1'b0, 1'b0}, '{32'h0707_a007, 3'h7, 1'b0, 1'b1}};

    lkt_command #(.ENTRIES(8), .AGE_CYCLES(2000)) lkt_command_i (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fwd_req(fwd_req), .fwd_mac(fwd_mac),
        .fwd_ack(fwd_ack), .fwd_done(fwd_done), .fwd_hit(fwd_hit), .fwd_drop(fwd_drop),
        .fwd_override(fwd_override), .fwd_ports(fwd_ports)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task print_verdict;
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // strobes drop after one edge and a spare edge follows, so calls may chain
    task wr(input logic [15:0] a, input logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task rd(input logic [15:0] a, output logic [31:0] v);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        v = reg_rdata;
    endtask : rd

    task bail(input int n);
        if (n >= 40) begin
            errors++;
            print_verdict();
        end
    endtask : bail

    // poll until neither make pending nor engine busy
    task idle;
        int n;
        logic [31:0] v;
        for (n = 0; n < 40; n++) begin
            rd(`LKT_STS_ADDR, v);
            if (v[1:0] === 2'h0) break;
        end
        bail(n);
    endtask : idle

    task mk(input logic [31:0] lo, input logic [31:0] hi, input logic pchk);
        wr(`LKT_WR_LO_ADDR, lo);
        wr(`LKT_WR_HI_ADDR, hi);
        wr(`LKT_CMD_ADDR, 32'h0000_0004);
        if (pchk) begin
            rd(`LKT_STS_ADDR, d);
            `CHK(d[0], 1'b1)
        end
        idle();
        wr(`LKT_CMD_ADDR, 32'h0000_0000);
    endtask : mk

    task look(input logic [47:0] m);
        int n;
        fwd_req <= 1'b1;
        fwd_mac <= m;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (fwd_ack === 1'b1) break;
        end
        bail(n);
        fwd_req <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            if (fwd_done === 1'b1) break;
        end
        bail(n);
    endtask : look

    // the bench clears the get bit itself before reading the result
    task get(input logic [31:0] c);
        wr(`LKT_CMD_ADDR, c);
        wr(`LKT_CMD_ADDR, 32'h0000_0000);
        idle();
        rd(`LKT_RD_LO_ADDR, d);
        rd(`LKT_RD_HI_ADDR, h);
    endtask : get

    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0000_0000;
        fwd_req = 1'b0;
        fwd_mac = 48'h0000_0000_0000;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        // reset values, unmapped word, reserved bits
        rd(`LKT_WR_LO_ADDR, d);
        `CHK(d, `LKT_WR_LO_RESET)
        rd(16'h1803, d);
        `CHK(d, 32'h0000_0000)
        wr(`LKT_WR_LO_ADDR, 32'h89ab_cdef);
        rd(`LKT_WR_LO_ADDR, d);
        `CHK(d, 32'h89ab_cdef)
        wr(`LKT_CMD_ADDR, 32'hffff_fff8);
        rd(`LKT_CMD_ADDR, d);
        `CHK(d, 32'h0000_0000)
        wr(`LKT_WR_HI_ADDR, 32'hffff_ffff);
        rd(`LKT_WR_HI_ADDR, d);
        `CHK(d, 32'h07ff_ffff)
        // fill the table, then look every row up
        for (i = 0; i < 8; i++) mk(32'h4455_6600 + i, rows[i].hi, 1'b1);
        for (i = 0; i < 8; i++) begin
            look({rows[i].hi[15:0], 32'h4455_6600 + i});
            `CHK(fwd_hit, 1'b1)
            `CHK(fwd_ports, rows[i].ports)
            `CHK(fwd_drop, rows[i].drop)
            `CHK(fwd_override, rows[i].ovr)
        end
        // walk the table past its end, then rewind
        for (i = 0; i < 9; i++) begin
            get(i == 0 ? 32'h0000_0002 : 32'h0000_0001);
            if (i < 8) `CHK(d, 32'h4455_6600 + i)
            else `CHK({h[31], h[26]}, 2'h2)
        end
        get(32'h0000_0002);
        `CHK(d, 32'h4455_6600)
        `CHK(h[26], 1'b1)
        // change an existing entry in place
        mk(32'h4455_6600, 32'h0506_a000, 1'b0);
        look({16'ha000, 32'h4455_6600});
        `CHK(fwd_ports, 3'h6)
        // a zero command does nothing; a make with valid clear removes the entry
        wr(`LKT_WR_LO_ADDR, 32'h4455_6607);
        wr(`LKT_WR_HI_ADDR, 32'h0307_a007);
        wr(`LKT_CMD_ADDR, 32'h0000_0000);
        idle();
        look({16'ha007, 32'h4455_6607});
        `CHK(fwd_hit, 1'b1)
        mk(32'h4455_6607, 32'h0307_a007, 1'b0);
        look({16'ha007, 32'h4455_6607});
        `CHK({fwd_hit, fwd_ports}, 4'h0)
        // free a slot; non-static age clear dies at the first sweep, age set outlives it
        mk(32'h4455_6606, 32'h0306_a006, 1'b0);
        mk(32'h0000_0001, 32'h0400_0001, 1'b1);
        mk(32'h0000_0002, 32'h0600_0002, 1'b0);
        for (i = 0; i < 50; i++) begin
            repeat (100) @(posedge sys_clk);
            look({16'h0001, 32'h0000_0001});
            if (fwd_hit === 1'b0) break;
        end
        `CHK(fwd_hit, 1'b0)
        look({16'h0002, 32'h0000_0002});
        `CHK(fwd_hit, 1'b1)
        look({16'ha001, 32'h4455_6601});
        `CHK(fwd_hit, 1'b1)
        // mid-run reset clears staging and empties the table
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(`LKT_WR_LO_ADDR, d);
        `CHK(d, `LKT_WR_LO_RESET)
        get(32'h0000_0002);
        `CHK({h[31], h[26]}, 2'h2)
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
